// ==== hdl/flmc_top.sv ====
/*
  Mode control of a dual-channel flash LED driver: shutdown and standby,
  flash, torch and infrared modes, current ramping, soft start,
  pass/boost choice, sync-input fallback and flash timeout.
  Assumes the analog side reports output-capacitor readiness and
  headroom loss as levels, and drives the serial bus open-drain.

// Notes on behaviour
// - enable pin low: shutdown, serial port off, all registers to default.
// - in shutdown every serial command is ignored without any answer.
// - enable pin high: standby, serial port answers commands.
// - flash on mode code 11 or enabled strobe pin; 128 levels per source.
// - flash start ramps each active source step by step to its target.
// - register-started flash clears all mode bits on timeout.
// - torch on mode code 10 or enabled torch pin set for torch use.
// - torch ramps step by step at a rate set in the timing register.
// - torch ignores flash timeout and the sync input.
// - infrared mode 01: pass mode, strobe level gates flash-level current.
// - infrared strobe is level sensitive; pulse timing is external.
// - infrared current switches at once, no ramp either way.
// - register soft start keeps source off until output capacitor ready.
// - converter starts in pass, boosts only when headroom is lost.
// - sync input high during flash drops current to torch level.
// - sync input low again before flash end restores flash level.
// - flash timeout turns current off whatever the sync input does.
// - sync input ignored while its enable bit 7 at 0x01 is zero.
// - torch/thermistor pin defaults to the torch function.
// - sixteen timeouts from 40ms to 1.6s, for flash and infrared.
// - timeout clears mode bits, sets flag bit 0 at 0x0A, read clears.
// - timeout keeps counting while sync input forces torch level.
*/
`timescale 1ns/1ps
module flmc_top import flmc_pkg::*; #(
  parameter int unsigned P_MS_CYC   = MS_CYC,
  parameter logic [6:0]  P_I2C_ADDR = I2C_ADDR_DEF
) (
  // clock and reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_rstn,
  // hardware control pins
  input  wire logic  i_hw_enable_pin,
  input  wire logic  i_strobe_pin,
  input  wire logic  i_torch_pin,
  input  wire logic  i_tx_pin,
  // serial bus
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  output logic       o_sda_out,
  output logic       o_sda_oe_n,
  // analog status
  input  wire logic  i_vout_ready,
  input  wire logic  i_headroom_low,
  // current sources and converter
  output flmc_drive_t o_drive,
  output logic       o_boost_en,
  output logic       o_shutdown
);

  function automatic logic [10:0] to_limit_ms(input logic [3:0] idx);
    int unsigned v;
    if (idx <= 4'(TO_KNEE_IDX)) begin
      v = TO_STEP_LO_MS * (int'(idx) + 1);
    end else begin
      v = TO_STEP_LO_MS * (TO_KNEE_IDX + 1)
        + TO_STEP_HI_MS * (int'(idx) - TO_KNEE_IDX);
    end
    return v[10:0];
  endfunction

  // ramp up by one on a step, drop straight to a lower target
  function automatic logic [LVL_W-1:0] step_to(
    input logic [LVL_W-1:0] cur,
    input logic [LVL_W-1:0] tgt,
    input logic             step
  );
    logic [LVL_W-1:0] r;
    r = cur;
    if (tgt < cur) begin
      r = tgt;
    end else if (step && cur < tgt) begin
      r = cur + 1'b1;
    end
    return r;
  endfunction

  // input synchronisers: enable, strobe, torch, tx
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_hw_enable_pin, i_strobe_pin,
                  i_torch_pin, i_tx_pin};
      sync2_q <= sync1_q;
    end
  end
  wire hw_enable_pin_s   = sync2_q[3];
  wire strobe_s = sync2_q[2];
  wire torch_s  = sync2_q[1];
  wire tx_s     = sync2_q[0];

  wire srst       = !i_rstn || !hw_enable_pin_s;
  wire i2c_rstn   = i_rstn & hw_enable_pin_s;

  // register port
  logic       i2c_wr, i2c_rd;
  logic [7:0] i2c_addr, i2c_wdata, rdata;

  flmc_i2c_slave #(
    .P_ADDR (P_I2C_ADDR)
  ) u_port (
    .i_clk      (i_ref_clk),
    .i_rstn     (i2c_rstn),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe_n (o_sda_oe_n),
    .o_wr       (i2c_wr),
    .o_rd       (i2c_rd),
    .o_addr     (i2c_addr),
    .o_wdata    (i2c_wdata),
    .i_rdata    (rdata)
  );
  assign o_sda_out = 1'b0;

  logic [7:0] en_q, fl_a_q, fl_b_q, tr_a_q, tr_b_q, tim_q, flags_q;

  wire wr_en     = i2c_wr && i2c_addr == OFF_ENABLE;
  wire wr_fl_a   = i2c_wr && i2c_addr == OFF_FLASH_A;
  wire wr_fl_b   = i2c_wr && i2c_addr == OFF_FLASH_B;
  wire wr_tr_a   = i2c_wr && i2c_addr == OFF_TORCH_A;
  wire wr_tr_b   = i2c_wr && i2c_addr == OFF_TORCH_B;
  wire wr_tim    = i2c_wr && i2c_addr == OFF_TIMING;
  wire rd_flags  = i2c_rd && i2c_addr == OFF_FAULT_FLAG_REG_ONE;

  assign rdata = (i2c_addr == OFF_ENABLE)  ? en_q   :
                 (i2c_addr == OFF_FLASH_A) ? fl_a_q :
                 (i2c_addr == OFF_FLASH_B) ? fl_b_q :
                 (i2c_addr == OFF_TORCH_A) ? tr_a_q :
                 (i2c_addr == OFF_TORCH_B) ? tr_b_q :
                 (i2c_addr == OFF_TIMING)  ? tim_q  :
                 (i2c_addr == OFF_FAULT_FLAG_REG_ONE)  ? flags_q : 8'h00;

  // mode decode
  flmc_state_t st_q, st_d;
  wire [1:0] mode      = {en_q[B_MODE_HI], en_q[B_MODE_LO]};
  wire ir_sel          = mode == MODE_IR;
  wire reg_flash       = mode == MODE_FLASH;
  wire reg_torch       = mode == MODE_TORCH;
  wire strobe_act      = en_q[B_STROBE_EN] & strobe_s;
  wire torch_pin_act   = en_q[B_TORCH_EN] & ~en_q[B_THERM_SEL]
                         & torch_s;
  wire flash_req       = reg_flash | (strobe_act & ~ir_sel);
  wire torch_req       = (reg_torch | torch_pin_act) & ~ir_sel;
  wire tx_act          = en_q[B_TX_EN] & tx_s;
  wire any_req         = flash_req | torch_req;

  // flash timeout counter, runs in flash and during an infrared pulse
  logic [31:0] cyc_q;
  logic [10:0] ms_q;
  wire timed     = st_q == ST_FLASH || (st_q == ST_IR && strobe_s);
  wire timeout_p = timed && ms_q >= to_limit_ms(tim_q[TO_MSB:TO_LSB]);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (ir_sel) begin
          st_d = ST_IR;
        end else if (any_req) begin
          // soft start only when the register starts the event
          if ((reg_flash | reg_torch) && !i_vout_ready) begin
            st_d = ST_SOFT;
          end else begin
            st_d = flash_req ? ST_FLASH : ST_TORCH;
          end
        end
      end
      ST_SOFT: begin
        if (!any_req || ir_sel) begin
          st_d = ST_IDLE;
        end else if (i_vout_ready) begin
          st_d = flash_req ? ST_FLASH : ST_TORCH;
        end
      end
      ST_FLASH: begin
        if (timeout_p) begin
          st_d = ST_TIMED;
        end else if (!flash_req) begin
          st_d = torch_req ? ST_TORCH : ST_IDLE;
        end
      end
      ST_TORCH: begin
        // no timeout exit here, torch runs until released
        if (flash_req) begin
          st_d = ST_FLASH;
        end else if (!torch_req) begin
          st_d = ST_IDLE;
        end
      end
      ST_IR: begin
        if (timeout_p) begin
          st_d = ST_TIMED;
        end else if (!ir_sel) begin
          st_d = ST_IDLE;
        end
      end
      ST_TIMED: begin
        // hold off until the strobe drops so a held pin cannot refire
        if (!strobe_act && !reg_flash && !ir_sel) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge i_ref_clk) begin
    if (srst) begin
      en_q    <= ENABLE_RST;
      fl_a_q  <= BRIGHT_RST;
      fl_b_q  <= BRIGHT_RST;
      tr_a_q  <= BRIGHT_RST;
      tr_b_q  <= BRIGHT_RST;
      tim_q   <= TIMING_RST;
      flags_q <= FAULT_FLAG_REG_ONE_RST;
    end else begin
      if (wr_en)   en_q   <= i2c_wdata;
      if (wr_fl_a) fl_a_q <= i2c_wdata;
      if (wr_fl_b) fl_b_q <= i2c_wdata;
      if (wr_tr_a) tr_a_q <= i2c_wdata;
      if (wr_tr_b) tr_b_q <= i2c_wdata;
      if (wr_tim)  tim_q  <= i2c_wdata;
      if (timeout_p) begin
        en_q[B_MODE_HI] <= 1'b0;
        en_q[B_MODE_LO] <= 1'b0;
      end
      if (rd_flags) flags_q <= FAULT_FLAG_REG_ONE_RST;
      if (timeout_p) flags_q[FLAG_TIMEOUT] <= 1'b1;
    end
  end

  // microsecond tick and ramp step divider
  logic [7:0] us_q, rcnt_q;
  wire us_tick  = us_q == 8'(US_CYC - 1);
  wire [7:0] rdiv = (st_q == ST_TORCH) ?
                    (8'h01 << tim_q[RAMP_MSB:RAMP_LSB]) : 8'h01;
  wire step     = us_tick && rcnt_q >= rdiv - 8'h01;

  // targets per state
  wire in_flash = st_q == ST_FLASH;
  wire in_torch = st_q == ST_TORCH;
  wire in_ir    = st_q == ST_IR;
  wire tx_cut   = in_flash & tx_act;
  wire [LVL_W-1:0] tgt_a = tx_cut   ? tr_a_q[LVL_W-1:0] :
                           in_flash ? fl_a_q[LVL_W-1:0] :
                           in_torch ? tr_a_q[LVL_W-1:0] :
                           in_ir    ? fl_a_q[LVL_W-1:0] : '0;
  wire [LVL_W-1:0] tgt_b = tx_cut   ? tr_b_q[LVL_W-1:0] :
                           in_flash ? fl_b_q[LVL_W-1:0] :
                           in_torch ? tr_b_q[LVL_W-1:0] :
                           in_ir    ? fl_b_q[LVL_W-1:0] : '0;
  wire ramping  = in_flash | in_torch;
  wire lit      = ramping | (in_ir & strobe_s);

  always_ff @(posedge i_ref_clk) begin
    if (srst) begin
      st_q       <= ST_IDLE;
      cyc_q      <= 32'h0;
      ms_q       <= 11'h0;
      us_q       <= 8'h00;
      rcnt_q     <= 8'h00;
      o_drive    <= '0;
      o_boost_en <= 1'b0;
    end else begin
      st_q <= st_d;
      if (!timed) begin
        cyc_q <= 32'h0;
        ms_q  <= 11'h0;
      end else if (cyc_q == P_MS_CYC - 1) begin
        cyc_q <= 32'h0;
        ms_q  <= ms_q + 11'h1;
      end else begin
        cyc_q <= cyc_q + 32'h1;
      end
      us_q <= us_tick ? 8'h00 : us_q + 8'h01;
      if (!ramping || step) begin
        rcnt_q <= 8'h00;
      end else if (us_tick) begin
        rcnt_q <= rcnt_q + 8'h01;
      end
      o_drive.on_a <= lit & en_q[B_SRC_A] & ~timeout_p;
      o_drive.on_b <= lit & en_q[B_SRC_B] & ~timeout_p;
      if (in_ir) begin
        o_drive.lvl_a <= strobe_s ? tgt_a : '0;
        o_drive.lvl_b <= strobe_s ? tgt_b : '0;
      end else if (ramping && !timeout_p) begin
        o_drive.lvl_a <= step_to(o_drive.lvl_a, tgt_a, step);
        o_drive.lvl_b <= step_to(o_drive.lvl_b, tgt_b, step);
      end else begin
        o_drive.lvl_a <= '0;
        o_drive.lvl_b <= '0;
      end
      // boost latches for the rest of the event once headroom is lost
      if (ramping && i_headroom_low) begin
        o_boost_en <= 1'b1;
      end else if (!ramping) begin
        o_boost_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_shutdown <= 1'b1;
    end else begin
      o_shutdown <= ~hw_enable_pin_s;
    end
  end

endmodule

// ==== hdl/flmc_pkg.sv ====
/*
  Shared constants and types of the flash LED mode-control block:
  register offsets, field positions, reset values, timing counts,
  mode codes, state enumerations and the current-source drive bundle.
  Assumes a single 200 MHz clock.
*/
package flmc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_US_NS    = 1000;
  localparam int unsigned TICK_MS_NS    = 1000000;
  localparam int unsigned US_CYC        = TICK_US_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_CYC        = TICK_MS_NS / CLK_PERIOD_NS;

  // flash timeout table: 16 steps, 40 ms .. 1600 ms
  localparam int unsigned TO_STEP_LO_MS = 40;
  localparam int unsigned TO_KNEE_IDX   = 9;
  localparam int unsigned TO_STEP_HI_MS = 200;

  // register offsets
  localparam logic [7:0] OFF_ENABLE  = 8'h01;
  localparam logic [7:0] OFF_FLASH_A = 8'h03;
  localparam logic [7:0] OFF_FLASH_B = 8'h04;
  localparam logic [7:0] OFF_TORCH_A = 8'h05;
  localparam logic [7:0] OFF_TORCH_B = 8'h06;
  localparam logic [7:0] OFF_TIMING  = 8'h08;
  localparam logic [7:0] OFF_FAULT_FLAG_REG_ONE  = 8'h0A;

  // reset values
  localparam logic [7:0] ENABLE_RST  = 8'h80;
  localparam logic [7:0] BRIGHT_RST  = 8'h3F;
  localparam logic [7:0] TIMING_RST  = 8'h1F;
  localparam logic [7:0] FAULT_FLAG_REG_ONE_RST  = 8'h00;

  // led_enable_control fields
  localparam int unsigned B_SRC_A     = 0;
  localparam int unsigned B_SRC_B     = 1;
  localparam int unsigned B_MODE_LO   = 2;
  localparam int unsigned B_MODE_HI   = 3;
  localparam int unsigned B_TORCH_EN  = 4;
  localparam int unsigned B_STROBE_EN = 5;
  localparam int unsigned B_THERM_SEL = 6;
  localparam int unsigned B_TX_EN     = 7;

  // timing register fields
  localparam int unsigned TO_LSB   = 0;
  localparam int unsigned TO_MSB   = 3;
  localparam int unsigned RAMP_LSB = 4;
  localparam int unsigned RAMP_MSB = 6;

  // fault_flag_reg_one fields
  localparam int unsigned FLAG_TIMEOUT = 0;

  // mode_select_hi, mode_select_lo codes
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_IR    = 2'h1;
  localparam logic [1:0] MODE_TORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;

  localparam int unsigned LVL_W        = 7;
  localparam logic [6:0]  I2C_ADDR_DEF = 7'h63;

  typedef struct packed {
    logic             on_a;
    logic             on_b;
    logic [LVL_W-1:0] lvl_a;
    logic [LVL_W-1:0] lvl_b;
  } flmc_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SOFT, ST_FLASH, ST_TORCH, ST_IR, ST_TIMED
  } flmc_state_t;

  typedef enum logic [2:0] {
    I_IDLE, I_RX, I_ACK, I_LOAD, I_TX, I_RACK
  } flmc_i2c_st_t;

endpackage

// ==== hdl/flmc_i2c_slave.sv ====
/*
  Byte-oriented serial register port: address match, register pointer,
  auto-incrementing writes and reads.
  Assumes SCL and SDA are already synchronous to i_clk and far slower.
*/
`timescale 1ns/1ps
module flmc_i2c_slave import flmc_pkg::*; #(
  parameter logic [6:0] P_ADDR = I2C_ADDR_DEF
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe_n,
  // register side
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata
);

  flmc_i2c_st_t st_q;
  logic         scl_q, sda_q, drv_q, rw_q, nack_q, wr_q, rd_q;
  logic [7:0]   sh_q, ptr_q, wdata_q;
  logic [3:0]   cnt_q;
  logic [1:0]   phase_q;
  logic         oe_n_q;

  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire start_c  = scl_q & i_scl & sda_q & ~i_sda;
  wire stop_c   = scl_q & i_scl & ~sda_q & i_sda;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_q    <= I_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      drv_q   <= 1'b0;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      wdata_q <= 8'h00;
      cnt_q   <= 4'h0;
      phase_q <= 2'h0;
      oe_n_q  <= 1'b1;
    end else begin
      // pin enable gets its own flop; one clock late is deep in scl low
      oe_n_q <= ~drv_q;
      scl_q <= i_scl;
      sda_q <= i_sda;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      if (start_c) begin
        st_q    <= I_RX;
        cnt_q   <= 4'h0;
        phase_q <= 2'h0;
        drv_q   <= 1'b0;
      end else if (stop_c) begin
        st_q  <= I_IDLE;
        drv_q <= 1'b0;
      end else if (st_q == I_LOAD) begin
        // data captured in the cycle the read strobe is seen
        sh_q  <= i_rdata;
        drv_q <= ~i_rdata[7];
        cnt_q <= 4'h0;
        st_q  <= I_TX;
      end else if (scl_rise) begin
        if (st_q == I_RX) begin
          sh_q  <= {sh_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == I_RACK) begin
          nack_q <= i_sda;
        end
      end else if (scl_fall) begin
        case (st_q)
          I_RX: begin
            if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (phase_q == 2'h0) begin
                if (sh_q[7:1] == P_ADDR) begin
                  rw_q  <= sh_q[0];
                  drv_q <= 1'b1;
                  st_q  <= I_ACK;
                end else begin
                  st_q <= I_IDLE;
                end
              end else begin
                drv_q <= 1'b1;
                st_q  <= I_ACK;
                if (phase_q == 2'h1) begin
                  ptr_q <= sh_q;
                end else begin
                  wr_q    <= 1'b1;
                  wdata_q <= sh_q;
                end
              end
            end
          end
          I_ACK: begin
            drv_q <= 1'b0;
            if (rw_q && phase_q == 2'h0) begin
              rd_q <= 1'b1;
              st_q <= I_LOAD;
            end else begin
              st_q    <= I_RX;
              phase_q <= (phase_q == 2'h0) ? 2'h1 : 2'h2;
              if (phase_q == 2'h2) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          I_TX: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              drv_q <= 1'b0;
              st_q  <= I_RACK;
            end else begin
              sh_q  <= {sh_q[6:0], 1'b0};
              drv_q <= ~sh_q[6];
            end
          end
          I_RACK: begin
            if (nack_q) begin
              st_q <= I_IDLE;
            end else begin
              ptr_q <= ptr_q + 8'h01;
              rd_q  <= 1'b1;
              st_q  <= I_LOAD;
            end
          end
          default: st_q <= I_IDLE;
        endcase
      end
    end
  end

  assign o_sda_oe_n = oe_n_q;
  assign o_wr       = wr_q;
  assign o_rd       = rd_q;
  assign o_addr     = ptr_q;
  assign o_wdata    = wdata_q;

endmodule

// ==== sim/flmc_monitor.sv ====
/*
  Port-level checks on the flash LED mode-control top.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
module flmc_monitor import flmc_pkg::*; (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  // watched pins
  input wire logic        i_hw_enable_pin,
  input wire logic        i_strobe_pin,
  input wire logic        i_scl,
  input wire logic        i_headroom_low,
  input wire logic        o_sda_oe_n,
  input wire flmc_drive_t o_drive,
  input wire logic        o_boost_en,
  input wire logic        o_shutdown
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence pin_held_hi;
    i_hw_enable_pin [*6];
  endsequence
  // infrared switching jumps levels, so only judge with strobe quiet
  sequence strobe_quiet;
    !i_strobe_pin [*5];
  endsequence

  shut_drive_a: assert property (o_shutdown |-> o_drive == '0)
    else $error("drive active in shutdown");
  shut_pass_a: assert property (o_shutdown |-> !o_boost_en)
    else $error("boost active in shutdown");
  shut_quiet_a: assert property (o_shutdown |-> o_sda_oe_n)
    else $error("data line driven in shutdown");
  pin_low_shut_a: assert property (
    $fell(i_hw_enable_pin) |-> ##[1:4] o_shutdown)
    else $error("no shutdown after enable pin fell");
  pin_hi_standby_a: assert property (pin_held_hi |-> !o_shutdown)
    else $error("still shut down with enable pin high");
  boost_cause_a: assert property (
    $rose(o_boost_en) |-> $past(i_headroom_low) ||
      $past(i_headroom_low, 2) || $past(i_headroom_low, 3))
    else $error("boost entered without headroom loss");
  ack_scl_low_a: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("data line pulled while clock high");
  sda_hold_a: assert property (
    i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
    else $error("data line moved while clock high");
  ramp_step_a: assert property (
    strobe_quiet ##0 (o_drive.on_a && $past(o_drive.on_a) &&
      o_drive.lvl_a > $past(o_drive.lvl_a)) |->
      o_drive.lvl_a == $past(o_drive.lvl_a) + 7'h01)
    else $error("current level skipped a step");
endmodule

bind flmc_top flmc_monitor i_flmc_monitor (
  .i_ref_clk      (i_ref_clk),
  .i_rstn         (i_rstn),
  .i_hw_enable_pin(i_hw_enable_pin),
  .i_strobe_pin   (i_strobe_pin),
  .i_scl          (i_scl),
  .i_headroom_low (i_headroom_low),
  .o_sda_oe_n     (o_sda_oe_n),
  .o_drive        (o_drive),
  .o_boost_en     (o_boost_en),
  .o_shutdown     (o_shutdown)
);

// ==== sim/flmc_host_model.sv ====
/*
  Host controller model for the serial register port.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
module flmc_host_model import flmc_pkg::*; #(
  parameter int unsigned P_MS = MS_CYC
) (
  // clock and bus
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  localparam int HP = 8; // half period, device needs at least 4 clk
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic hp();
    repeat (HP) @(negedge i_clk);
  endtask
  // host may not talk until the enable pin has been high 2 ms
  task automatic power_wait();
    repeat (2 * P_MS) @(negedge i_clk);
  endtask
  task automatic start();
    o_sda = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b1;
    hp();
  endtask
  task automatic bit_x(input logic b, output logic r);
    o_sda = b;
    hp();
    o_scl = 1'b1;
    hp();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, nak);
  endtask
  task automatic write_reg(input logic [7:0] a, d, output logic nak);
    logic n0, n1, n2;
    start();
    tx_byte({I2C_ADDR_DEF, 1'b0}, n0);
    tx_byte(a, n1);
    tx_byte(d, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic nak);
    logic n0, n1, n2, r;
    start();
    tx_byte({I2C_ADDR_DEF, 1'b0}, n0);
    tx_byte(a, n1);
    start();
    tx_byte({I2C_ADDR_DEF, 1'b1}, n2);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(1'b1, r); // nack ends the read
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule

// ==== sim/flash_led_mode_control_tb.sv ====
/*
  Self-checking bench for the flash LED mode-control top.
  Assumes the host model and the bound port monitor alongside.
*/
`timescale 1ns/1ps
module flash_led_mode_control_tb import flmc_pkg::*;;
  localparam int MS = 200; // scaled millisecond keeps timeouts short
  logic        ref_clk, rstn, hw_enable_pin, strobe, torch, tx, vrdy, hlow;
  logic        scl, sda_h, sda_oen, boost, shut, nk;
  logic [7:0]  d;
  flmc_drive_t drv;
  int          n_mismatch, checks_done;
  int          cyc_n = 0;
  wire logic   sda = sda_h & sda_oen;

  flmc_top #(.P_MS_CYC(MS)) i_flmc_top (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .i_hw_enable_pin(hw_enable_pin),
    .i_strobe_pin(strobe), .i_torch_pin(torch), .i_tx_pin(tx),
    .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe_n(sda_oen),
    .i_vout_ready(vrdy), .i_headroom_low(hlow), .o_drive(drv),
    .o_boost_en(boost), .o_shutdown(shut));
  flmc_host_model #(.P_MS(MS)) i_flmc_host_model (
    .i_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc_n <= cyc_n + 1;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, v);
    i_flmc_host_model.write_reg(a, v, nk);
    chk(nk, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    i_flmc_host_model.read_reg(a, d, nk);
    chk({nk, d}, {1'b0, exp});
  endtask
  task automatic wait_off();
    int n = 0;
    while (drv.on_a === 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      $display("ERROR t=%0t drive never switched off", $time);
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic t_defaults();
    rd(OFF_ENABLE, ENABLE_RST);
    rd(OFF_TIMING, TIMING_RST);
    rd(OFF_FAULT_FLAG_REG_ONE, FAULT_FLAG_REG_ONE_RST);
    rd(8'h7E, 8'h00);
  endtask
  task automatic t_shutdown();
    wr(OFF_FLASH_A, 8'h11);
    hw_enable_pin = 1'b0;
    cyc(6);
    chk(shut, 1'b1);
    i_flmc_host_model.write_reg(OFF_FLASH_A, 8'h22, nk);
    chk(nk, 1'b1);
    hw_enable_pin = 1'b1;
    i_flmc_host_model.power_wait();
    chk(shut, 1'b0);
    rd(OFF_FLASH_A, BRIGHT_RST);
  endtask
  task automatic t_torch();
    vrdy = 1'b0;
    wr(OFF_TORCH_A, 8'h05);
    wr(OFF_TIMING, 8'h00);
    wr(OFF_ENABLE, 8'h89);
    cyc(300);
    chk(drv.on_a, 1'b0);
    vrdy = 1'b1;
    cyc(3 * US_CYC);
    chk(drv.lvl_a inside {[1:4]}, 1'b1);
    cyc(3 * US_CYC);
    chk({drv.on_a, drv.on_b, drv.lvl_a}, {2'b10, 7'h05});
    tx = 1'b1;
    hlow = 1'b1;
    cyc(60 * MS); // well past the 40 ms timeout
    chk({drv.on_a, drv.lvl_a}, {1'b1, 7'h05});
    chk(boost, 1'b1);
    tx = 1'b0;
    hlow = 1'b0;
    wr(OFF_ENABLE, 8'h80);
    cyc(10);
    chk({boost, drv.on_a}, 2'b00);
  endtask
  task automatic t_flash();
    int st;
    wr(OFF_FLASH_A, 8'h04);
    wr(OFF_TORCH_A, 8'h02);
    wr(OFF_ENABLE, 8'h8D);
    st = cyc_n;
    cyc(2 * US_CYC);
    chk(drv.lvl_a inside {[1:3]}, 1'b1);
    cyc(3 * US_CYC);
    chk({drv.on_a, drv.lvl_a}, {1'b1, 7'h04});
    tx = 1'b1;
    cyc(5);
    chk(drv.lvl_a, 7'h02);
    tx = 1'b0;
    cyc(2 * US_CYC + 10);
    chk(drv.lvl_a, 7'h04);
    tx = 1'b1;
    wait_off();
    chk((cyc_n - st) inside {[7900:8020]}, 1'b1);
    chk(drv.on_a, 1'b0);
    tx = 1'b0;
    rd(OFF_ENABLE, 8'h81);
    rd(OFF_FAULT_FLAG_REG_ONE, 8'h01);
    rd(OFF_FAULT_FLAG_REG_ONE, 8'h00);
  endtask
  task automatic t_ir();
    wr(OFF_FLASH_A, 8'h06);
    wr(OFF_ENABLE, 8'h87);
    hlow = 1'b1;
    strobe = 1'b1;
    cyc(4);
    chk(drv, {2'b11, 7'h06, 7'h3F});
    chk(boost, 1'b0);
    cyc(100);
    strobe = 1'b0;
    cyc(4);
    chk({drv.on_a, drv.on_b}, 2'b00);
    hlow = 1'b0;
  endtask
  task automatic t_pins();
    wr(OFF_ENABLE, 8'h91);
    torch = 1'b1;
    cyc(2 * US_CYC);
    chk(drv.on_a, 1'b1);
    torch = 1'b0;
    cyc(10);
    wr(OFF_ENABLE, 8'h21);
    tx = 1'b1;
    strobe = 1'b1;
    cyc(8 * US_CYC);
    chk({drv.on_a, drv.lvl_a}, {1'b1, 7'h06});
    strobe = 1'b0;
    tx = 1'b0;
    cyc(10);
    chk(drv.on_a, 1'b0);
  endtask

  initial begin
    rstn = 1'b0;
    hw_enable_pin = 1'b1;
    strobe = 1'b0;
    torch = 1'b0;
    tx = 1'b0;
    vrdy = 1'b1;
    hlow = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cyc(8);
    rstn = 1'b1;
    i_flmc_host_model.power_wait();
    t_defaults();
    t_shutdown();
    t_torch();
    t_flash();
    t_ir();
    t_pins();
    wrap_up();
  end
endmodule
